// [shared/rmc_cfg.svh]
// constants of the main configuration register bank
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH

// ****************************************
// register indices (byte address is 4x)
// ****************************************
`define RMC_NUM_REGS        12
`define RMC_IDX_W           5
`define RMC_IDX_STATE_BAND  5'h00
`define RMC_IDX_DATA_MOD    5'h01
`define RMC_IDX_DEVIATION   5'h02
`define RMC_IDX_COEFF_C     5'h03
`define RMC_IDX_COEFF_D     5'h04
`define RMC_IDX_RAMP_TRIM   5'h05
`define RMC_IDX_SET1_REF    5'h06
`define RMC_IDX_SET1_MAIN   5'h07
`define RMC_IDX_SET1_SWAL   5'h08
`define RMC_IDX_SET2_REF    5'h09
`define RMC_IDX_SET2_MAIN   5'h0A
`define RMC_IDX_SET2_SWAL   5'h0B

// ****************************************
// group boundaries (last index of each)
// ****************************************
`define RMC_GRP_MAIN_LAST   5'h0B
`define RMC_GRP_INTR_LAST   5'h0F
`define RMC_GRP_RECV_LAST   5'h15
`define RMC_GRP_PAT_LAST    5'h19
`define RMC_GRP_XMIT_LAST   5'h1A
`define RMC_GRP_XTAL_LAST   5'h1B
`define RMC_GRP_PKT_LAST    5'h1E

// ****************************************
// field positions
// ****************************************
`define RMC_F_OPSTATE       7:5
`define RMC_F_BAND          4:2
`define RMC_F_QUARTER       1:0
`define RMC_F_DATAMODE      7:6
`define RMC_F_MODSEL        5:4
`define RMC_F_SLICER        3:2
`define RMC_F_IFGAIN        1:0
`define RMC_F_RAMP          7:6
`define RMC_F_LOWPWR        5
`define RMC_F_TRIM          2:1
`define RMC_F_BANKSEL       0
`define RMC_RAMP_TRIM_MASK  8'hE7
`define RMC_COEFF_D_MIN     8'h0F

// ****************************************
// reset values
// ****************************************
`define RMC_RST_STATE_BAND  8'h30
`define RMC_RST_DATA_MOD    8'h24
`define RMC_RST_DEVIATION   8'h00
`define RMC_RST_COEFF_C     8'h07
`define RMC_RST_COEFF_D     8'h0F
`define RMC_RST_RAMP_TRIM   8'hC6
`define RMC_RST_SET1_REF    8'h6B
`define RMC_RST_SET1_MAIN   8'h2A
`define RMC_RST_SET1_SWAL   8'h1E
`define RMC_RST_SET2_REF    8'h77
`define RMC_RST_SET2_MAIN   8'h2F
`define RMC_RST_SET2_SWAL   8'h19

// ****************************************
// ramp times and their cycle counts
// ****************************************
`define RMC_CLK_MHZ         125
`define RMC_RAMP0_NS        3000
`define RMC_RAMP1_NS        8500
`define RMC_RAMP2_NS        15000
`define RMC_RAMP3_NS        23000
`define RMC_NS2CYC(t)       (((t) * `RMC_CLK_MHZ + 999) / 1000)

`endif

// [shared/rmc_pkg.sv]
// types of the main configuration register bank
`include "rmc_cfg.svh"
package rmc_pkg;

  typedef enum logic [2:0] {
    RMC_OP_SLEEP,
    RMC_OP_STANDBY,
    RMC_OP_SYNTH,
    RMC_OP_RECEIVE,
    RMC_OP_TRANSMIT,
    RMC_OP_UNDEF
  } rmc_op_t;

  typedef enum logic [1:0] {
    RMC_DATA_CONT,
    RMC_DATA_BUFF,
    RMC_DATA_PACKET
  } rmc_data_t;

  typedef enum logic [1:0] {
    RMC_MOD_RESET,
    RMC_MOD_OOK,
    RMC_MOD_FSK,
    RMC_MOD_DIRECT
  } rmc_mod_t;

  typedef enum logic [1:0] {
    RMC_SLC_FIXED,
    RMC_SLC_PEAK,
    RMC_SLC_AVERAGE,
    RMC_SLC_RESERVED
  } rmc_slicer_t;

  typedef enum logic [2:0] {
    RMC_GRP_MAIN,
    RMC_GRP_INTR,
    RMC_GRP_RECV,
    RMC_GRP_PATTERN,
    RMC_GRP_XMIT,
    RMC_GRP_XTAL,
    RMC_GRP_PACKET,
    RMC_GRP_NONE
  } rmc_group_t;

  typedef logic [`RMC_NUM_REGS-1:0][7:0] rmc_regs_t;

  typedef struct packed {
    rmc_op_t     op_state;
    logic [2:0]  band;
    logic [1:0]  quarter;
    rmc_data_t   data_mode;
    rmc_mod_t    modulation;
    rmc_slicer_t slicer;
    logic [1:0]  if_atten;
    logic [7:0]  deviation;
    logic [7:0]  coeff_c;
    logic [7:0]  coeff_d;
    logic        coeff_d_low;
    logic [1:0]  ramp_code;
    logic [11:0] ramp_cycles;
    logic        low_power_rx;
    logic [1:0]  vco_trim;
    logic        bank_choice;
    logic [7:0]  active_ref;
    logic [7:0]  active_main;
    logic [7:0]  active_swallow;
  } rmc_dec_t;

endpackage

// [shared/rmc_cfg_if.sv]
// carrier between the register bank and its field decoder
`timescale 1ns/1ps
`default_nettype none
interface rmc_cfg_if;
  import rmc_pkg::*;
  rmc_regs_t regs;
  rmc_dec_t  dec;
  modport bank (output regs, input dec);
  modport decoder (input regs, output dec);
endinterface
`default_nettype wire

// [verilog/rmc_decode.sv]
// field decoder turning raw register bytes into registered settings
`timescale 1ns/1ps
`default_nettype none
`include "rmc_cfg.svh"
module rmc_decode
  import rmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  rmc_cfg_if.decoder cfg
);

  rmc_dec_t st_r;
  rmc_dec_t st_nxt;

  localparam logic [11:0] RAMP0_CYC = 12'(`RMC_NS2CYC(`RMC_RAMP0_NS));
  localparam logic [11:0] RAMP1_CYC = 12'(`RMC_NS2CYC(`RMC_RAMP1_NS));
  localparam logic [11:0] RAMP2_CYC = 12'(`RMC_NS2CYC(`RMC_RAMP2_NS));
  localparam logic [11:0] RAMP3_CYC = 12'(`RMC_NS2CYC(`RMC_RAMP3_NS));

  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b5;
  assign b0 = cfg.regs[`RMC_IDX_STATE_BAND];
  assign b1 = cfg.regs[`RMC_IDX_DATA_MOD];
  assign b5 = cfg.regs[`RMC_IDX_RAMP_TRIM];

  always_comb begin
    st_nxt = st_r;
    case (b0[`RMC_F_OPSTATE])
      3'h0:    st_nxt.op_state = RMC_OP_SLEEP;
      3'h1:    st_nxt.op_state = RMC_OP_STANDBY;
      3'h2:    st_nxt.op_state = RMC_OP_SYNTH;
      3'h3:    st_nxt.op_state = RMC_OP_RECEIVE;
      3'h4:    st_nxt.op_state = RMC_OP_TRANSMIT;
      default: st_nxt.op_state = RMC_OP_UNDEF;
    endcase
    st_nxt.band    = b0[`RMC_F_BAND];
    st_nxt.quarter = b0[`RMC_F_QUARTER];
    if (b1[7]) begin
      st_nxt.data_mode = RMC_DATA_PACKET;
    end else if (b1[6]) begin
      st_nxt.data_mode = RMC_DATA_BUFF;
    end else begin
      st_nxt.data_mode = RMC_DATA_CONT;
    end
    st_nxt.modulation  = rmc_mod_t'(b1[`RMC_F_MODSEL]);
    st_nxt.slicer      = rmc_slicer_t'(b1[`RMC_F_SLICER]);
    st_nxt.if_atten    = b1[`RMC_F_IFGAIN];
    st_nxt.deviation   = cfg.regs[`RMC_IDX_DEVIATION];
    st_nxt.coeff_c     = cfg.regs[`RMC_IDX_COEFF_C];
    st_nxt.coeff_d     = cfg.regs[`RMC_IDX_COEFF_D];
    // flags a host slip; the value is kept as written
    st_nxt.coeff_d_low = cfg.regs[`RMC_IDX_COEFF_D] < `RMC_COEFF_D_MIN;
    st_nxt.ramp_code   = b5[`RMC_F_RAMP];
    case (b5[`RMC_F_RAMP])
      2'h0:    st_nxt.ramp_cycles = RAMP0_CYC;
      2'h1:    st_nxt.ramp_cycles = RAMP1_CYC;
      2'h2:    st_nxt.ramp_cycles = RAMP2_CYC;
      default: st_nxt.ramp_cycles = RAMP3_CYC;
    endcase
    st_nxt.low_power_rx = b5[`RMC_F_LOWPWR];
    st_nxt.vco_trim     = b5[`RMC_F_TRIM];
    st_nxt.bank_choice  = b5[`RMC_F_BANKSEL];
    if (b5[`RMC_F_BANKSEL]) begin
      st_nxt.active_ref     = cfg.regs[`RMC_IDX_SET2_REF];
      st_nxt.active_main    = cfg.regs[`RMC_IDX_SET2_MAIN];
      st_nxt.active_swallow = cfg.regs[`RMC_IDX_SET2_SWAL];
    end else begin
      st_nxt.active_ref     = cfg.regs[`RMC_IDX_SET1_REF];
      st_nxt.active_main    = cfg.regs[`RMC_IDX_SET1_MAIN];
      st_nxt.active_swallow = cfg.regs[`RMC_IDX_SET1_SWAL];
    end
  end

  // decoded view of the reset register image
  localparam rmc_dec_t DEC_RST = '{
    op_state:       RMC_OP_STANDBY,
    band:           3'h4,
    quarter:        2'h0,
    data_mode:      RMC_DATA_CONT,
    modulation:     RMC_MOD_FSK,
    slicer:         RMC_SLC_PEAK,
    if_atten:       2'h0,
    deviation:      `RMC_RST_DEVIATION,
    coeff_c:        `RMC_RST_COEFF_C,
    coeff_d:        `RMC_RST_COEFF_D,
    coeff_d_low:    1'b0,
    ramp_code:      2'h3,
    ramp_cycles:    RAMP3_CYC,
    low_power_rx:   1'b0,
    vco_trim:       2'h3,
    bank_choice:    1'b0,
    active_ref:     `RMC_RST_SET1_REF,
    active_main:    `RMC_RST_SET1_MAIN,
    active_swallow: `RMC_RST_SET1_SWAL
  };

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= DEC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg.dec = st_r;

  // ****************************************
  // checks
  // ****************************************
  chk_synth_decode: assert property (@(posedge clk) disable iff (rst)
    b0[`RMC_F_OPSTATE] == 3'h2 |=> st_r.op_state == RMC_OP_SYNTH)
    else $error("synth state code not decoded");

  chk_packet_mode: assert property (@(posedge clk) disable iff (rst)
    b1[7] |=> st_r.data_mode == RMC_DATA_PACKET)
    else $error("upper data mode bit did not give packet mode");

  chk_bank_mux: assert property (@(posedge clk) disable iff (rst)
    b5[0] |=> st_r.active_ref == $past(cfg.regs[`RMC_IDX_SET2_REF]))
    else $error("second counter set not selected");

endmodule
`default_nettype wire

// [verilog/rmc_top.sv]
// main configuration register bank with a classic wishbone slave
// Behaviour
// - state bits 7-5 of reg 0: sleep, standby, synth, receive, transmit
// - band field bits 4-2 of reg 0, six codes, 430-470 default
// - bits 1-0 of reg 0 pick quarter of the band, first default
// - data mode bits 7-6 of reg 1: continuous, buffered, else packet
// - modulation bits 5-4 of reg 1, FSK default, 11 reserved
// - slicer type bits 3-2 of reg 1, peak default, 11 reserved
// - IF gain bits 1-0 of reg 1, zero is maximum gain
// - reg 2 holds full 8-bit FSK deviation
// - reg 3 holds rate coefficient C, any value allowed
// - reg 4 holds coefficient D; host keeps it 15..255; defaults 7,15
// - ramp time bits 7-6 of reg 5, 3 to 23 us, 23 default
// - bit 5 of reg 5 enables low power receive, reset zero
// - VCO trim bits 2-1 of reg 5, reset 11
// - bit 0 of reg 5 selects active counter set, zero default
// - first counter set at regs 6-8, used while select is zero
// - second counter set at regs 9-11, used while select is one
// - space split into main, interrupt, receive, pattern, tx, osc, packet
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rmc_cfg.svh"
module rmc_top
  import rmc_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output rmc_group_t       access_group,
  output rmc_op_t          op_state,
  output logic [2:0]       band,
  output logic [1:0]       quarter,
  output rmc_data_t        data_mode,
  output rmc_mod_t         modulation,
  output rmc_slicer_t      slicer,
  output logic [1:0]       if_atten,
  output logic [7:0]       deviation,
  output logic [7:0]       coeff_c,
  output logic [7:0]       coeff_d,
  output logic             coeff_d_low,
  output logic [1:0]       ramp_code,
  output logic [11:0]      ramp_cycles,
  output logic             low_power_rx,
  output logic [1:0]       vco_trim,
  output logic             bank_choice,
  output logic [7:0]       active_ref,
  output logic [7:0]       active_main,
  output logic [7:0]       active_swallow
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic        ack;
    logic [7:0]  dat;
    rmc_group_t  grp;
    rmc_regs_t   regs;
  } rmc_bank_t;

  localparam rmc_regs_t REGS_RST = {
    `RMC_RST_SET2_SWAL,
    `RMC_RST_SET2_MAIN,
    `RMC_RST_SET2_REF,
    `RMC_RST_SET1_SWAL,
    `RMC_RST_SET1_MAIN,
    `RMC_RST_SET1_REF,
    `RMC_RST_RAMP_TRIM,
    `RMC_RST_COEFF_D,
    `RMC_RST_COEFF_C,
    `RMC_RST_DEVIATION,
    `RMC_RST_DATA_MOD,
    `RMC_RST_STATE_BAND
  };

  localparam rmc_bank_t BANK_RST = '{
    ack:  1'b0,
    dat:  8'h00,
    grp:  RMC_GRP_NONE,
    regs: REGS_RST
  };

  rmc_bank_t st_r;
  rmc_bank_t st_nxt;

  rmc_cfg_if cfg ();

  // ****************************************
  // address decoding
  // ****************************************
  // the bank answers every address; only main group bytes hold storage,
  // the other groups live in sibling blocks and read zero here
  function automatic rmc_group_t group_of(
    input logic [AW-1:0] adr
  );
    logic [`RMC_IDX_W-1:0] idx;
    idx = adr[6:2];
    if (adr[AW-1:7] != '0) begin
      group_of = RMC_GRP_NONE;
    end else if (idx <= `RMC_GRP_MAIN_LAST) begin
      group_of = RMC_GRP_MAIN;
    end else if (idx <= `RMC_GRP_INTR_LAST) begin
      group_of = RMC_GRP_INTR;
    end else if (idx <= `RMC_GRP_RECV_LAST) begin
      group_of = RMC_GRP_RECV;
    end else if (idx <= `RMC_GRP_PAT_LAST) begin
      group_of = RMC_GRP_PATTERN;
    end else if (idx <= `RMC_GRP_XMIT_LAST) begin
      group_of = RMC_GRP_XMIT;
    end else if (idx <= `RMC_GRP_XTAL_LAST) begin
      group_of = RMC_GRP_XTAL;
    end else if (idx <= `RMC_GRP_PKT_LAST) begin
      group_of = RMC_GRP_PACKET;
    end else begin
      group_of = RMC_GRP_NONE;
    end
  endfunction

  // bits 4-3 of the ramp register are unassigned and read zero
  function automatic logic [7:0] write_mask(
    input logic [`RMC_IDX_W-1:0] idx
  );
    if (idx == `RMC_IDX_RAMP_TRIM) begin
      write_mask = `RMC_RAMP_TRIM_MASK;
    end else begin
      write_mask = 8'hFF;
    end
  endfunction

  logic                  req;
  logic [`RMC_IDX_W-1:0] idx;
  rmc_group_t            grp;
  logic                  commit;

  assign req    = wb_cyc_i && wb_stb_i;
  assign idx    = wb_adr_i[6:2];
  assign grp    = group_of(wb_adr_i);
  // writes land on the edge where the master sees ack, not earlier
  assign commit = req && st_r.ack && wb_we_i && wb_sel_i[0] &&
                  grp == RMC_GRP_MAIN;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req && !st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.grp = grp;
      if (grp == RMC_GRP_MAIN) begin
        st_nxt.dat = st_r.regs[idx];
      end else begin
        st_nxt.dat = 8'h00;
      end
    end
    if (commit) begin
      st_nxt.regs[idx] = wb_dat_i[7:0] & write_mask(idx);
      if (idx == `RMC_IDX_DEVIATION || idx == `RMC_IDX_COEFF_C) begin
        st_nxt.regs[idx] = wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= BANK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cfg.regs     = st_r.regs;
  assign wb_ack_o     = st_r.ack;
  assign wb_dat_o     = {24'h000000, st_r.dat};
  assign access_group = st_r.grp;

  rmc_decode u_decode (
    .clk (clk),
    .rst (rst),
    .cfg (cfg)
  );

  assign op_state       = cfg.dec.op_state;
  assign band           = cfg.dec.band;
  assign quarter        = cfg.dec.quarter;
  assign data_mode      = cfg.dec.data_mode;
  assign modulation     = cfg.dec.modulation;
  assign slicer         = cfg.dec.slicer;
  assign if_atten       = cfg.dec.if_atten;
  assign deviation      = cfg.dec.deviation;
  assign coeff_c        = cfg.dec.coeff_c;
  assign coeff_d        = cfg.dec.coeff_d;
  assign coeff_d_low    = cfg.dec.coeff_d_low;
  assign ramp_code      = cfg.dec.ramp_code;
  assign ramp_cycles    = cfg.dec.ramp_cycles;
  assign low_power_rx   = cfg.dec.low_power_rx;
  assign vco_trim       = cfg.dec.vco_trim;
  assign bank_choice    = cfg.dec.bank_choice;
  assign active_ref     = cfg.dec.active_ref;
  assign active_main    = cfg.dec.active_main;
  assign active_swallow = cfg.dec.active_swallow;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_taken;
    req && !wb_ack_o;
  endsequence

  sequence s_answered;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_answer;
    s_taken |=> s_answered;
  endproperty

  chk_ack_timing: assert property (p_answer)
    else $error("request not answered in one cycle");

  chk_group_tag: assert property (
    s_taken |=> access_group == group_of($past(wb_adr_i)))
    else $error("access group not recorded");

  chk_other_zero: assert property (
    s_taken ##0 (grp != RMC_GRP_MAIN) |=> wb_dat_o == 32'h00000000)
    else $error("non-main group read not zero");

  chk_readback_word: assert property (
    s_taken ##0 (grp == RMC_GRP_MAIN) |=>
      wb_dat_o[7:0] == st_r.regs[$past(idx)])
    else $error("read data does not match stored byte");

  chk_write_commit: assert property (
    commit && idx == `RMC_IDX_COEFF_C |=>
      ##1 coeff_c == $past(wb_dat_i[7:0], 2))
    else $error("rate coefficient C not forwarded");

  chk_state_default: assert property (
    $past(rst) |-> op_state == RMC_OP_STANDBY && band == 3'h4 &&
      quarter == 2'h0)
    else $error("state or band default wrong");

  chk_mod_default: assert property (
    $past(rst) |-> modulation == RMC_MOD_FSK &&
      slicer == RMC_SLC_PEAK && data_mode == RMC_DATA_CONT &&
      if_atten == 2'h0)
    else $error("data or modulation defaults wrong");

  chk_rate_default: assert property (
    $past(rst) |-> coeff_c == 8'h07 && coeff_d == 8'h0F && !coeff_d_low)
    else $error("rate coefficient defaults wrong");

  chk_trim_default: assert property (
    $past(rst) |-> vco_trim == 2'h3 && ramp_code == 2'h3 &&
      ramp_cycles == 12'd2875 && !low_power_rx)
    else $error("ramp or trim defaults wrong");

  chk_set1_default: assert property (
    $past(rst) |-> !bank_choice && active_ref == 8'h6B &&
      active_main == 8'h2A && active_swallow == 8'h1E)
    else $error("first counter set defaults wrong");

  chk_lowpwr_write: assert property (
    commit && idx == `RMC_IDX_RAMP_TRIM |=>
      ##1 low_power_rx == $past(wb_dat_i[5], 2))
    else $error("low power receive bit not applied");

  chk_set_select: assert property (
    commit && idx == `RMC_IDX_RAMP_TRIM && wb_dat_i[0] |=>
      ##1 bank_choice && active_main == st_r.regs[`RMC_IDX_SET2_MAIN])
    else $error("counter set select not applied");

  chk_gap_bits: assert property (
    st_r.regs[`RMC_IDX_RAMP_TRIM][4:3] == 2'h0)
    else $error("unassigned ramp register bits set");

  chk_no_stray: assert property (
    !req |=> !wb_ack_o)
    else $error("ack without request");

  // a landed write reaches the decoded outputs two edges later: one edge
  // for the bank, one for the decoder flop
  chk_opstate_write: assert property (
    commit && idx == `RMC_IDX_STATE_BAND && wb_dat_i[7:5] <= 3'h4 |=>
      ##1 op_state == $past(wb_dat_i[7:5], 2))
    else $error("operating state not applied");

  chk_band_write: assert property (
    commit && idx == `RMC_IDX_STATE_BAND |=>
      ##1 band == $past(wb_dat_i[4:2], 2) &&
      quarter == $past(wb_dat_i[1:0], 2))
    else $error("band or quarter field not applied");

  chk_datamode_write: assert property (
    commit && idx == `RMC_IDX_DATA_MOD && !wb_dat_i[7] |=>
      ##1 data_mode == $past(wb_dat_i[7:6], 2))
    else $error("continuous or buffered mode not applied");

  chk_mod_write: assert property (
    commit && idx == `RMC_IDX_DATA_MOD |=>
      ##1 modulation == $past(wb_dat_i[5:4], 2))
    else $error("modulation select not applied");

  chk_slicer_write: assert property (
    commit && idx == `RMC_IDX_DATA_MOD |=>
      ##1 slicer == $past(wb_dat_i[3:2], 2))
    else $error("slicer type not applied");

  chk_dev_write: assert property (
    commit && idx == `RMC_IDX_DEVIATION |=>
      ##1 deviation == $past(wb_dat_i[7:0], 2))
    else $error("deviation not applied");

  chk_coeffd_write: assert property (
    commit && idx == `RMC_IDX_COEFF_D |=>
      ##1 coeff_d == $past(wb_dat_i[7:0], 2) &&
      coeff_d_low == ($past(wb_dat_i[7:0], 2) < `RMC_COEFF_D_MIN))
    else $error("rate coefficient D or its flag not applied");

  chk_ramp_write: assert property (
    commit && idx == `RMC_IDX_RAMP_TRIM |=>
      ##1 ramp_code == $past(wb_dat_i[7:6], 2))
    else $error("ramp time code not applied");

  chk_trim_write: assert property (
    commit && idx == `RMC_IDX_RAMP_TRIM |=>
      ##1 vco_trim == $past(wb_dat_i[2:1], 2))
    else $error("vco trim not applied");

  chk_set1_select: assert property (
    commit && idx == `RMC_IDX_RAMP_TRIM && !wb_dat_i[0] |=>
      ##1 !bank_choice && active_ref == st_r.regs[`RMC_IDX_SET1_REF])
    else $error("first counter set not selected");

  chk_dat_hold: assert property (
    !(req && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved without a request");

  chk_sel_ignored: assert property (
    req && wb_ack_o && wb_we_i && !wb_sel_i[0] |=> $stable(st_r.regs))
    else $error("write without low byte enable changed a register");

endmodule
`default_nettype wire

// [sim/rmc_host.sv]
// host model: classic wishbone master that programs the register bank
`timescale 1ns/1ps
`default_nettype none
module rmc_host (
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
  end

  // released lines show the inverse pattern so stale data never matches
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q, output bit to);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = dat_o;
    to = (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    adr <= ~a;
    dat <= ~d;
  endtask
endmodule
`default_nettype wire

// [sim/rmc_top_test.sv]
// self-checking bench of the main configuration register bank
`timescale 1ns/1ps
`default_nettype none
module rmc_top_test;
  import rmc_pkg::*;
  logic clk, rst, cyc, stb, we, ack, d_low, lp_rx, bank;
  logic [7:0] adr, dev, c_c, c_d, a_ref, a_main, a_swal;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, q;
  logic [2:0] band;
  logic [1:0] quarter, if_att, ramp, trim;
  logic [11:0] ramp_cyc;
  rmc_group_t grp_o;
  rmc_op_t op;
  rmc_data_t dm;
  rmc_mod_t md;
  rmc_slicer_t slc;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 39980;
  int i;
  logic [7:0] d;
  logic [7:0] sh [12];
  localparam logic [7:0] RST_B [12] = '{8'h30, 8'h24, 8'h00, 8'h07,
    8'h0F, 8'hC6, 8'h6B, 8'h2A, 8'h1E, 8'h77, 8'h2F, 8'h19};
  localparam logic [11:0] RAMP_C [4] = '{12'd375, 12'd1063, 12'd1875,
    12'd2875};

  rmc_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat(dat_i), .dat_o(dat_o), .ack(ack));
  rmc_top #(.AW(8)) uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .access_group(grp_o), .op_state(op), .band(band), .quarter(quarter),
    .data_mode(dm), .modulation(md), .slicer(slc), .if_atten(if_att),
    .deviation(dev), .coeff_c(c_c), .coeff_d(c_d), .coeff_d_low(d_low),
    .ramp_code(ramp), .ramp_cycles(ramp_cyc), .low_power_rx(lp_rx),
    .vco_trim(trim), .bank_choice(bank), .active_ref(a_ref),
    .active_main(a_main), .active_swallow(a_swal));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic acc(logic w, logic [7:0] a, logic [31:0] dd,
                     logic [3:0] s);
    bit to;
    host.xfer(w, a, dd, s, q, to);
    if (to) begin
      n_mismatch++;
      $display("Error wb_ack_o expected 1 seen 0");
      summarize();
    end
  endtask

  // host side keeps every field inside its defined codes
  function automatic logic [7:0] legal(int k, logic [7:0] v);
    if (k == 0) v[7:5] = v[7:5] % 5;
    if (k == 0 && v[4:2] > 5) v[4:2] = v[4:2] - 3'h2;
    if (k == 1 && v[5:4] == 2'h3) v[5] = 1'b0;
    if (k == 1 && v[3:2] == 2'h3) v[3] = 1'b0;
    if (k == 4 && v < 8'h0F) v = v | 8'h10;
    return v;
  endfunction

  function automatic rmc_group_t exp_grp(logic [7:0] a);
    int k;
    k = a[6:2];
    if (a[7]) return RMC_GRP_NONE;
    if (k < 12) return RMC_GRP_MAIN;
    if (k < 16) return RMC_GRP_INTR;
    if (k < 22) return RMC_GRP_RECV;
    if (k < 26) return RMC_GRP_PATTERN;
    if (k == 26) return RMC_GRP_XMIT;
    if (k == 27) return RMC_GRP_XTAL;
    if (k < 31) return RMC_GRP_PACKET;
    return RMC_GRP_NONE;
  endfunction

  task automatic chk_fields();
    int b;
    b = sh[5][0] ? 9 : 6;
    cmp("op_state", sh[0][7:5] > 4 ? RMC_OP_UNDEF : sh[0][7:5], op);
    cmp("band", sh[0][4:2], band);
    cmp("quarter", sh[0][1:0], quarter);
    cmp("data_mode", sh[1][7] ? 2'h2 : {1'b0, sh[1][6]}, dm);
    cmp("modulation", sh[1][5:4], md);
    cmp("slicer", sh[1][3:2], slc);
    cmp("if_atten", sh[1][1:0], if_att);
    cmp("deviation", sh[2], dev);
    cmp("coeff_c", sh[3], c_c);
    cmp("coeff_d", sh[4], c_d);
    cmp("coeff_d_low", sh[4] < 8'h0F, d_low);
    cmp("ramp_code", sh[5][7:6], ramp);
    cmp("ramp_cycles", RAMP_C[sh[5][7:6]], ramp_cyc);
    cmp("low_power_rx", sh[5][5], lp_rx);
    cmp("vco_trim", sh[5][2:1], trim);
    cmp("bank_choice", sh[5][0], bank);
    cmp("active_ref", sh[b], a_ref);
    cmp("active_main", sh[b+1], a_main);
    cmp("active_swallow", sh[b+2], a_swal);
  endtask

  // write, read back, then look at the decoded outputs
  task automatic wr_chk(int k, logic [7:0] v, logic [3:0] s);
    acc(1'b1, 8'(k * 4), {$random(seed)} & 32'hFFFF_FF00 | v, s);
    if (s[0]) sh[k] = (k == 5) ? (v & 8'hE7) : v;
    acc(1'b0, 8'(k * 4), 32'h0000_0000, 4'hF);
    cmp("read_data", {24'h0, sh[k]}, q);
    cmp("access_group", RMC_GRP_MAIN, grp_o);
    #1;
    chk_fields();
  endtask

  initial begin
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 12; i++) sh[i] = RST_B[i];
    @(posedge clk);
    #1;
    cmp("access_group", RMC_GRP_NONE, grp_o);
    chk_fields();
    for (i = 0; i < 12; i++) begin
      acc(1'b0, 8'(i * 4), 32'h0000_0000, 4'hF);
      cmp("reset_value", {24'h0, RST_B[i]}, q);
    end
    for (i = 0; i < 240; i++) begin
      d = 8'($random(seed));
      wr_chk(i % 12, legal(i % 12, d), 4'hF);
    end
    wr_chk(4, 8'h0E, 4'hF);
    wr_chk(4, 8'h0F, 4'hF);
    wr_chk(3, 8'hFF, 4'hE);
    wr_chk(5, 8'hFF, 4'hF);
    // second reset in mid-run: every register and field falls back
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 12; i++) sh[i] = RST_B[i];
    @(posedge clk);
    #1;
    cmp("access_group", RMC_GRP_NONE, grp_o);
    chk_fields();
    for (i = 12; i < 64; i++) begin
      d = (i < 32) ? 8'(i * 4) : 8'h80 | 8'((i - 32) * 4);
      acc(1'b1, d, $random(seed), 4'hF);
      acc(1'b0, d, 32'h0000_0000, 4'hF);
      cmp("read_data", 32'h0000_0000, q);
      @(posedge clk);
      #1;
      cmp("access_group", exp_grp(d), grp_o);
      chk_fields();
    end
    summarize();
  end
endmodule
`default_nettype wire
